// *** include/acc_map.svh ***
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ACC_ADDR_STATUS 6'h00
`define ACC_ADDR_CONTROL 6'h01
`define ACC_ADDR_DATA 6'h02
`define ACC_ADDR_IO_CONTROL 6'h03
`define ACC_ADDR_ERROR_EN 6'h04
`define ACC_ADDR_ERROR 6'h05
`define ACC_COEF_PAGE 2'h1

// ----------------------------------------
// fields, codes and reset values
// ----------------------------------------
`define ACC_CTL_BIPOLAR 4
`define ACC_CTL_SETUP_LSB 5
`define ACC_STS_PENDING 7
`define ACC_STS_BUSY 6
`define ACC_MODE_IDLE 4'h4
`define ACC_MODE_SEQ_IDLE_SYNC 4'h9
`define ACC_MODE_SEQ_STBY_SYNC 4'ha
`define ACC_MODE_INT_OFFSET 4'h5
`define ACC_MODE_INT_GAIN 4'h6
`define ACC_MODE_SYS_OFFSET 4'h7
`define ACC_MODE_SYS_GAIN 4'h8
`define ACC_GAIN_UNITY 3'h0
`define ACC_OFFSET_RESET 16'h8000
`define ACC_GAIN_RESET 16'h5555
`define ACC_MID_CODE 18'sh08000
`define ACC_GAIN_NUM 32'h1fffe000

// ----------------------------------------
// timing counts
// ----------------------------------------
`define ACC_IGAIN_CONVS 3'h4
`define ACC_CAL_CONVS 3'h1
`define ACC_DIV_STEPS 6'h20

`endif

// *** include/acc_pkg.sv ***
package acc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CAL,
        ST_DIV,
        ST_PP1,
        ST_PP2
    } acc_state_t;
endpackage

// *** hdl/acc_coef_mem.sv ***
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_coef_mem #(
    parameter int SETUPS = 8,
    parameter int IW = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // write port
    input wire logic we,
    input wire logic wr_gain,
    input wire logic [IW-1:0] wr_idx,
    input wire logic [15:0] wr_data,
    // host read port
    input wire logic [IW-1:0] rd_idx,
    input wire logic rd_gain,
    output logic [15:0] rd_data,
    // active setup port
    input wire logic [IW-1:0] act_idx,
    output logic [15:0] act_offset,
    output logic [15:0] act_gain
);
    typedef struct packed {
        logic [SETUPS-1:0][15:0] off;
        logic [SETUPS-1:0][15:0] gain;
        logic [15:0] rd;
        logic [15:0] a_off;
        logic [15:0] a_gain;
    } acc_mem_t;

    acc_mem_t mem_ff;
    acc_mem_t nxt_mem;

    // write, plus registered reads of both ports taken from the contents before that write
    always_comb begin
        nxt_mem = mem_ff;
        if (we) begin
            if (wr_gain) begin
                nxt_mem.gain[wr_idx] = wr_data;
            end else begin
                nxt_mem.off[wr_idx] = wr_data;
            end
        end
        nxt_mem.rd = rd_gain ? mem_ff.gain[rd_idx] : mem_ff.off[rd_idx];
        nxt_mem.a_off = mem_ff.off[act_idx];
        nxt_mem.a_gain = mem_ff.gain[act_idx];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_ff.off <= {SETUPS{`ACC_OFFSET_RESET}};
            mem_ff.gain <= {SETUPS{`ACC_GAIN_RESET}};
            mem_ff.rd <= 16'h0000;
            mem_ff.a_off <= `ACC_OFFSET_RESET;
            mem_ff.a_gain <= `ACC_GAIN_RESET;
        end else begin
            mem_ff <= nxt_mem;
        end
    end

    assign rd_data = mem_ff.rd;
    assign act_offset = mem_ff.a_off;
    assign act_gain = mem_ff.a_gain;
endmodule // acc_coef_mem

// *** hdl/acc_top.sv ***
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_top (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // serial port
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // strobe pin
    input wire logic sync_n,
    // converter core
    input wire logic conv_done,
    input wire logic [15:0] raw_code,
    input wire logic conv_fault,
    input wire logic [2:0] amplifier_gain_field,
    input wire logic amplifier_bypass,
    // control outputs
    output logic data_ready_n,
    output logic modulator_reset,
    output logic fifo_clear,
    output logic exit_idle,
    output logic exit_standby,
    output logic route_full_scale,
    output logic short_inputs
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] sclk_s;
        logic sclk_d;
        logic [1:0] cs_s;
        logic [1:0] mosi_s;
        logic [1:0] sync_s;
        logic sync_d;
        logic [4:0] bit_cnt;
        logic [15:0] sh;
        logic [7:0] cmd;
        logic [1:0] ld;
        logic [15:0] tx;
        logic miso;
        logic oe;
        logic [3:0] mode;
        logic bipolar;
        logic [2:0] setup;
        logic fifo_flush_on_strobe;
        logic err_en;
        logic err_flag;
        logic result_pending_flag;
        logic drdy_n;
        logic drdy_hold;
        acc_pkg::acc_state_t st;
        logic [2:0] conv_cnt;
        logic [15:0] raw;
        logic [34:0] prod;
        logic [17:0] rem;
        logic [31:0] quo;
        logic [17:0] divisor;
        logic [5:0] div_cnt;
        logic we;
        logic wr_gain;
        logic [2:0] wr_idx;
        logic [15:0] wr_data;
        logic [15:0] data;
        logic mod_rst;
        logic fifo_clr;
        logic exit_idle;
        logic exit_stby;
        logic route_fs;
        logic short_in;
    } acc_core_t;

    acc_core_t cur_ff;
    acc_core_t nxt_cur;
    logic [15:0] host_rd;
    logic [15:0] act_off;
    logic [15:0] act_gain;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic is_coef(input logic [5:0] a);
        is_coef = (a[5:4] == `ACC_COEF_PAGE);
    endfunction

    function automatic logic is_cal(input logic [3:0] m);
        is_cal = (m == `ACC_MODE_INT_OFFSET) || (m == `ACC_MODE_INT_GAIN) ||
                 (m == `ACC_MODE_SYS_OFFSET) || (m == `ACC_MODE_SYS_GAIN);
    endfunction

    function automatic logic [15:0] clamp16(input logic signed [34:0] v);
        if (v < 0) begin
            clamp16 = 16'h0000;
        end else if (v > 35'sh0ffff) begin
            clamp16 = 16'hffff;
        end else begin
            clamp16 = v[15:0];
        end
    endfunction

    // coefficient store; host port addressed from the latched command
    acc_coef_mem #(
        .SETUPS(8),
        .IW(3)
    ) u_mem (
        .clk(clk),
        .rstn(rstn),
        .we(cur_ff.we),
        .wr_gain(cur_ff.wr_gain),
        .wr_idx(cur_ff.wr_idx),
        .wr_data(cur_ff.wr_data),
        .rd_idx(cur_ff.cmd[2:0]),
        .rd_gain(cur_ff.cmd[3]),
        .rd_data(host_rd),
        .act_idx(cur_ff.setup),
        .act_offset(act_off),
        .act_gain(act_gain)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic sync_rise;
        logic [15:0] wd;
        logic [15:0] rv;
        logic [17:0] t;
        logic [2:0] need;
        logic signed [17:0] diff;
        logic signed [34:0] scaled;
        rise = 1'b0;
        fall = 1'b0;
        sync_rise = 1'b0;
        wd = 16'h0000;
        rv = 16'h0000;
        t = 18'h00000;
        need = `ACC_CAL_CONVS;
        diff = 18'sh00000;
        scaled = 35'sh0;
        nxt_cur = cur_ff;
        nxt_cur.we = 1'b0;
        // calibration results land in the active setup; host writes override below
        nxt_cur.wr_idx = cur_ff.setup;
        nxt_cur.exit_idle = 1'b0;
        nxt_cur.exit_stby = 1'b0;

        // pin synchronisers; only the second stage is looked at
        nxt_cur.sclk_s = {cur_ff.sclk_s[0], sclk};
        nxt_cur.cs_s = {cur_ff.cs_s[0], cs_n};
        nxt_cur.mosi_s = {cur_ff.mosi_s[0], mosi};
        nxt_cur.sync_s = {cur_ff.sync_s[0], sync_n};
        nxt_cur.sclk_d = cur_ff.sclk_s[1];
        nxt_cur.sync_d = cur_ff.sync_s[1];
        rise = cur_ff.sclk_s[1] & ~cur_ff.sclk_d;
        fall = ~cur_ff.sclk_s[1] & cur_ff.sclk_d;
        sync_rise = cur_ff.sync_s[1] & ~cur_ff.sync_d;

        // corrected raw code, shared by scaling and gain calibration
        diff = $signed({{2{cur_ff.raw[15]}}, cur_ff.raw}) -
               ($signed({2'b00, act_off}) - `ACC_MID_CODE);

        // read value for the latched command
        if (is_coef(cur_ff.cmd[5:0])) begin
            rv = (cur_ff.st == acc_pkg::ST_IDLE) ? host_rd : 16'h0000;
        end else begin
            unique case (cur_ff.cmd[5:0])
                `ACC_ADDR_STATUS: begin
                    rv[`ACC_STS_PENDING] = cur_ff.result_pending_flag;
                    rv[`ACC_STS_BUSY] = (cur_ff.st == acc_pkg::ST_CAL) ||
                                        (cur_ff.st == acc_pkg::ST_DIV);
                end
                `ACC_ADDR_CONTROL: begin
                    rv[3:0] = cur_ff.mode;
                    rv[`ACC_CTL_BIPOLAR] = cur_ff.bipolar;
                    rv[`ACC_CTL_SETUP_LSB +: 3] = cur_ff.setup;
                end
                `ACC_ADDR_DATA: rv = cur_ff.data;
                `ACC_ADDR_IO_CONTROL: rv[0] = cur_ff.fifo_flush_on_strobe;
                `ACC_ADDR_ERROR_EN: rv[0] = cur_ff.err_en;
                `ACC_ADDR_ERROR: rv[0] = cur_ff.err_flag;
                default: rv = 16'h0000;
            endcase
        end

        // serial frame: command byte then one data word
        nxt_cur.ld = {cur_ff.ld[0], 1'b0};
        if (cur_ff.ld[1]) begin
            nxt_cur.tx = rv;
        end
        if (cur_ff.cs_s[1]) begin
            nxt_cur.bit_cnt = 5'h00;
            nxt_cur.oe = 1'b0;
        end else if (rise) begin
            nxt_cur.sh = {cur_ff.sh[14:0], cur_ff.mosi_s[1]};
            nxt_cur.bit_cnt = cur_ff.bit_cnt + 5'h01;
            if (cur_ff.bit_cnt == 5'h07) begin
                nxt_cur.cmd = {cur_ff.sh[6:0], cur_ff.mosi_s[1]};
                nxt_cur.ld = {cur_ff.ld[0], cur_ff.sh[5]};
                if (cur_ff.sh[5] && ({cur_ff.sh[4:0], cur_ff.mosi_s[1]} == `ACC_ADDR_DATA)) begin
                    nxt_cur.drdy_n = 1'b1;
                end
            end
            if ((cur_ff.bit_cnt == 5'h17) && !cur_ff.cmd[6]) begin
                wd = {cur_ff.sh[14:0], cur_ff.mosi_s[1]};
                if (is_coef(cur_ff.cmd[5:0])) begin
                    if (cur_ff.st == acc_pkg::ST_IDLE) begin
                        nxt_cur.we = 1'b1;
                        nxt_cur.wr_gain = cur_ff.cmd[3];
                        nxt_cur.wr_idx = cur_ff.cmd[2:0];
                        nxt_cur.wr_data = wd;
                    end
                end else begin
                    unique case (cur_ff.cmd[5:0])
                        `ACC_ADDR_CONTROL: begin
                            if (cur_ff.st == acc_pkg::ST_IDLE) begin
                                nxt_cur.bipolar = wd[`ACC_CTL_BIPOLAR];
                                nxt_cur.setup = wd[`ACC_CTL_SETUP_LSB +: 3];
                                nxt_cur.mode = wd[3:0];
                                if ((wd[3:0] == `ACC_MODE_INT_GAIN) && !amplifier_bypass &&
                                    (amplifier_gain_field == `ACC_GAIN_UNITY)) begin
                                    nxt_cur.mode = `ACC_MODE_IDLE;
                                end else if (is_cal(wd[3:0])) begin
                                    nxt_cur.st = acc_pkg::ST_CAL;
                                    nxt_cur.conv_cnt = 3'h0;
                                    nxt_cur.drdy_n = 1'b1;
                                    nxt_cur.drdy_hold = 1'b0;
                                    nxt_cur.result_pending_flag = 1'b1;
                                end
                            end
                        end
                        `ACC_ADDR_IO_CONTROL: nxt_cur.fifo_flush_on_strobe = wd[0];
                        `ACC_ADDR_ERROR_EN: nxt_cur.err_en = wd[0];
                        `ACC_ADDR_ERROR: begin
                            if (wd[0]) begin
                                nxt_cur.err_flag = 1'b0;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end else if (fall && (cur_ff.bit_cnt >= 5'h08) && cur_ff.cmd[6]) begin
            nxt_cur.miso = cur_ff.tx[15];
            nxt_cur.tx = {cur_ff.tx[14:0], 1'b0};
            nxt_cur.oe = 1'b1;
        end

        // calibration sequencing and post-processing
        unique case (cur_ff.st)
            acc_pkg::ST_IDLE: begin
                if (conv_done) begin
                    nxt_cur.raw = raw_code;
                    nxt_cur.st = acc_pkg::ST_PP1;
                end
            end
            acc_pkg::ST_CAL: begin
                if (cur_ff.err_en && conv_fault) begin
                    nxt_cur.err_flag = 1'b1;
                end
                need = (cur_ff.mode == `ACC_MODE_INT_GAIN) ? `ACC_IGAIN_CONVS : `ACC_CAL_CONVS;
                if (conv_done) begin
                    nxt_cur.raw = raw_code;
                    nxt_cur.conv_cnt = cur_ff.conv_cnt + 3'h1;
                    if (cur_ff.conv_cnt + 3'h1 == need) begin
                        if ((cur_ff.mode == `ACC_MODE_INT_GAIN) ||
                            (cur_ff.mode == `ACC_MODE_SYS_GAIN)) begin
                            nxt_cur.st = acc_pkg::ST_DIV;
                            nxt_cur.div_cnt = 6'h00;
                        end else begin
                            nxt_cur.we = 1'b1;
                            nxt_cur.wr_gain = 1'b0;
                            nxt_cur.wr_data = raw_code + `ACC_OFFSET_RESET;
                            nxt_cur.st = acc_pkg::ST_IDLE;
                        end
                    end
                end
            end
            acc_pkg::ST_DIV: begin
                // restoring divide: nominal full scale over corrected code
                if (cur_ff.div_cnt == 6'h00) begin
                    nxt_cur.divisor = diff;
                    nxt_cur.rem = 18'h00000;
                    nxt_cur.quo = `ACC_GAIN_NUM;
                    nxt_cur.div_cnt = 6'h01;
                    if (diff <= 0) begin
                        nxt_cur.we = 1'b1;
                        nxt_cur.wr_gain = 1'b1;
                        nxt_cur.wr_data = 16'hffff;
                        nxt_cur.st = acc_pkg::ST_IDLE;
                    end
                end else if (cur_ff.div_cnt <= `ACC_DIV_STEPS) begin
                    t = {cur_ff.rem[16:0], cur_ff.quo[31]};
                    if (t >= cur_ff.divisor) begin
                        nxt_cur.rem = t - cur_ff.divisor;
                        nxt_cur.quo = {cur_ff.quo[30:0], 1'b1};
                    end else begin
                        nxt_cur.rem = t;
                        nxt_cur.quo = {cur_ff.quo[30:0], 1'b0};
                    end
                    nxt_cur.div_cnt = cur_ff.div_cnt + 6'h01;
                end else begin
                    nxt_cur.we = 1'b1;
                    nxt_cur.wr_gain = 1'b1;
                    nxt_cur.wr_data = (|cur_ff.quo[31:16]) ? 16'hffff : cur_ff.quo[15:0];
                    nxt_cur.st = acc_pkg::ST_IDLE;
                end
            end
            acc_pkg::ST_PP1: begin
                nxt_cur.prod = 35'(diff * $signed({1'b0, act_gain}));
                nxt_cur.st = acc_pkg::ST_PP2;
            end
            acc_pkg::ST_PP2: begin
                if (cur_ff.bipolar) begin
                    scaled = ($signed(cur_ff.prod) >>> 14) + 35'sh08000;
                end else begin
                    scaled = $signed(cur_ff.prod) >>> 13;
                end
                nxt_cur.data = clamp16(scaled);
                nxt_cur.drdy_n = 1'b0;
                nxt_cur.result_pending_flag = 1'b0;
                nxt_cur.st = acc_pkg::ST_IDLE;
            end
        endcase

        // calibration end: clear flag, return idle, hold ready
        if ((cur_ff.st != acc_pkg::ST_IDLE) && (nxt_cur.st == acc_pkg::ST_IDLE) &&
            (cur_ff.st != acc_pkg::ST_PP2)) begin
            nxt_cur.result_pending_flag = 1'b0;
            nxt_cur.mode = `ACC_MODE_IDLE;
            nxt_cur.drdy_hold = 1'b1;
        end
        // after calibration, ready falls only with select low
        if (cur_ff.drdy_hold && !cur_ff.cs_s[1]) begin
            nxt_cur.drdy_n = 1'b0;
            nxt_cur.drdy_hold = 1'b0;
        end

        nxt_cur.route_fs = (nxt_cur.st == acc_pkg::ST_CAL) &&
                           (nxt_cur.mode == `ACC_MODE_INT_GAIN);
        nxt_cur.short_in = (nxt_cur.st == acc_pkg::ST_CAL) &&
                           (nxt_cur.mode == `ACC_MODE_INT_OFFSET);

        // strobe pin low flushes fifo when fifo_flush_on_strobe is set, otherwise holds modulator
        nxt_cur.fifo_clr = cur_ff.fifo_flush_on_strobe & ~cur_ff.sync_s[1];
        nxt_cur.mod_rst = ~cur_ff.fifo_flush_on_strobe & ~cur_ff.sync_s[1];
        if (!cur_ff.fifo_flush_on_strobe && !cur_ff.sync_s[1]) begin
            nxt_cur.drdy_n = 1'b1;
            nxt_cur.drdy_hold = 1'b0;
        end
        // strobe rising edge wakes the sequencer
        if (sync_rise) begin
            nxt_cur.exit_idle = (cur_ff.mode == `ACC_MODE_SEQ_IDLE_SYNC);
            nxt_cur.exit_stby = (cur_ff.mode == `ACC_MODE_SEQ_STBY_SYNC);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '0;
            cur_ff.sclk_s <= 2'h3;
            cur_ff.sclk_d <= 1'b1;
            cur_ff.cs_s <= 2'h3;
            cur_ff.sync_s <= 2'h3;
            cur_ff.sync_d <= 1'b1;
            cur_ff.mode <= `ACC_MODE_IDLE;
            cur_ff.drdy_n <= 1'b1;
            cur_ff.result_pending_flag <= 1'b1;
            cur_ff.st <= acc_pkg::ST_IDLE;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from the state register
    assign miso = cur_ff.miso;
    assign miso_oe = cur_ff.oe;
    assign data_ready_n = cur_ff.drdy_n;
    assign modulator_reset = cur_ff.mod_rst;
    assign fifo_clear = cur_ff.fifo_clr;
    assign exit_idle = cur_ff.exit_idle;
    assign exit_standby = cur_ff.exit_stby;
    assign route_full_scale = cur_ff.route_fs;
    assign short_inputs = cur_ff.short_in;
endmodule // acc_top

// *** tb/acc_host.sv ***
`timescale 1ns/1ps
module acc_host (
    // clock
    input wire logic clk,
    // serial port
    output logic sclk = 1'b1,
    output logic cs_n = 1'b1,
    output logic mosi = 1'b0,
    input wire logic miso
);
    // ----
    // host side of the serial port
    // ----
    // command then data
    task automatic xfer(input logic [7:0] c, input logic [15:0] d, output logic [15:0] r);
        logic [23:0] s;
        s = {c, d};
        r = 16'h0;
        @(posedge clk) cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 23; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= s[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            if (i < 16) r = {r[14:0], miso};
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~mosi; // idle line never keeps the last bit
        repeat (4) @(posedge clk);
    endtask
endmodule // acc_host

// *** tb/acc_top_assertions.sv ***
`timescale 1ns/1ps
module acc_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pins
    input wire logic cs_n,
    input wire logic miso_oe,
    input wire logic sync_n,
    input wire logic data_ready_n,
    input wire logic modulator_reset,
    input wire logic fifo_clear,
    input wire logic exit_idle,
    input wire logic exit_standby,
    input wire logic route_full_scale,
    input wire logic short_inputs
);
    // ----
    // port relations
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // strobe level must have passed the synchroniser first
    sequence s_strobe_low;
        !sync_n [*5];
    endsequence
    a_strobe_one_target: assert property (!(fifo_clear && modulator_reset))
        else $error("flush and modulator reset both high");
    a_strobe_low_acts: assert property (s_strobe_low |-> fifo_clear || modulator_reset)
        else $error("strobe low had no effect");
    a_strobe_high_quiet: assert property (sync_n [*5] |-> !fifo_clear && !modulator_reset)
        else $error("strobe effect while strobe high");
    a_wake_pulse_once: assert property (exit_idle || exit_standby |=> !exit_idle && !exit_standby)
        else $error("wake pulse longer than one cycle");
    a_wake_one_kind: assert property (!(exit_idle && exit_standby))
        else $error("both wake pulses at once");
    a_cal_paths_apart: assert property (!(route_full_scale && short_inputs))
        else $error("full scale and shorted inputs together");
    a_cal_start_ready: assert property ($rose(route_full_scale || short_inputs) |-> data_ready_n)
        else $error("ready low at calibration start");
    a_cal_ready_high: assert property (route_full_scale || short_inputs |-> data_ready_n)
        else $error("ready low during calibration");
    a_miso_quiet: assert property (cs_n [*5] |-> !miso_oe)
        else $error("miso driven while deselected");
endmodule // acc_chk
bind acc_top acc_chk i_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .miso_oe(miso_oe),
    .sync_n(sync_n), .data_ready_n(data_ready_n), .modulator_reset(modulator_reset),
    .fifo_clear(fifo_clear), .exit_idle(exit_idle), .exit_standby(exit_standby),
    .route_full_scale(route_full_scale), .short_inputs(short_inputs));

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    // ----
    // pins, tasks and tests
    // ----
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sync_n = 1'b1;
    logic conv_done = 1'b0;
    logic conv_fault = 1'b0;
    logic [2:0] gain_f = 3'h1;
    logic byp = 1'b0;
    logic [15:0] raw_code = 16'h0;
    logic sclk, cs_n, mosi, miso, miso_oe, drdy_n, mod_rst, fclr, ex_i, ex_s, rfs, shrt;
    logic [1:0] hit;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [15:0] raw_t [4] = '{16'h1000, 16'h1000, 16'h7fff, 16'hc000};
    logic [15:0] off_t [4] = '{16'h8000, 16'h8100, 16'h8000, 16'h8000};
    logic [15:0] gn_t [4] = '{16'h4000, 16'h5555, 16'hffff, 16'h4000};
    logic bip_t [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    initial begin
        forever #2 clk = ~clk;
    end
    acc_top i_dut (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .sync_n(sync_n), .conv_done(conv_done), .raw_code(raw_code),
        .conv_fault(conv_fault), .amplifier_gain_field(gain_f), .amplifier_bypass(byp),
        .data_ready_n(drdy_n), .modulator_reset(mod_rst), .fifo_clear(fclr), .exit_idle(ex_i),
        .exit_standby(ex_s), .route_full_scale(rfs), .short_inputs(shrt));
    acc_host i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] r;
        i_host.xfer({2'b00, a}, d, r);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] r;
        i_host.xfer({2'b01, a}, 16'h0, r);
        check(r, e);
    endtask
    // core result pulse; raw bus goes stale afterwards on purpose
    task automatic conv(input logic [15:0] r);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_fault <= 1'b1;
        raw_code <= r;
        @(posedge clk);
        conv_done <= 1'b0;
        conv_fault <= 1'b0;
        raw_code <= ~r;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    function automatic logic [15:0] scale(input logic [15:0] r, o, g, input logic b);
        longint p;
        p = (longint'($signed(r)) - longint'(o) + 32768) * longint'(g);
        p = b ? (p >>> 14) + 32768 : p >>> 13;
        return (p < 0) ? 16'h0 : (p > 65535) ? 16'hffff : p[15:0];
    endfunction
    task automatic cal(input logic [3:0] m, input logic [15:0] r, input int n,
        input logic [5:0] a, input logic [15:0] e);
        wr(6'h01, {12'h0, m});
        @(negedge clk);
        check(drdy_n, 16'h1);
        rchk(6'h00, 16'h00c0);
        rchk(a, 16'h0);
        wr(6'h17, 16'h1234);
        for (int i = 0; i < n; i++) begin
            check({rfs, shrt}, {m == 4'h6, m == 4'h5});
            conv(r);
        end
        repeat (60) @(posedge clk);
        rchk(a, e);
        rchk(6'h00, 16'h0000);
        rchk(6'h17, 16'h8000);
        check(drdy_n, 16'h0);
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int n = 0; n < 8; n++) begin
            rchk(6'h10 + n[5:0], 16'h8000);
            rchk(6'h18 + n[5:0], 16'h5555);
        end
        wr(6'h1b, 16'h1234);
        rchk(6'h1b, 16'h1234);
        rchk(6'h3f, 16'h0);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            wr(6'h10, off_t[k]);
            wr(6'h18, gn_t[k]);
            wr(6'h01, {11'h0, bip_t[k], 4'h4});
            conv(raw_t[k]);
            check(drdy_n, 16'h0);
            rchk(6'h02, scale(raw_t[k], off_t[k], gn_t[k], bip_t[k]));
            check(drdy_n, 16'h1);
        end
        $display("test scaling done");
        // bench reference stays under 2 V, so doubled range is left clear
        // internal gain, internal offset, then system pair
        wr(6'h10, 16'h8000);
        cal(4'h6, 16'h3000, 4, 6'h18, 16'haaaa);
        cal(4'h5, 16'h0010, 1, 6'h10, 16'h8010);
        rchk(6'h05, 16'h0);
        wr(6'h04, 16'h1);
        cal(4'h7, 16'h0020, 1, 6'h10, 16'h8020);
        cal(4'h8, 16'h3020, 1, 6'h18, 16'haaaa);
        rchk(6'h05, 16'h1);
        wr(6'h05, 16'h1);
        rchk(6'h05, 16'h0);
        gain_f <= 3'h0;
        wr(6'h01, 16'h6);
        rchk(6'h01, 16'h4);
        // gain setting changed, so recalibrate, now with bypass on
        byp <= 1'b1;
        wr(6'h10, 16'h8000);
        cal(4'h6, 16'h3000, 4, 6'h18, 16'haaaa);
        byp <= 1'b0;
        gain_f <= 3'h1;
        $display("test calibration done");
        for (int f = 0; f < 4; f++) begin
            wr(6'h03, {15'h0, f[1]});
            wr(6'h01, {12'h0, f[0] ? 4'ha : 4'h9});
            sync_n <= 1'b0;
            repeat (8) @(negedge clk);
            check({fclr, mod_rst}, f[1] ? 16'h2 : 16'h1);
            @(posedge clk);
            sync_n <= 1'b1;
            hit = 2'b0;
            repeat (8) @(negedge clk) hit = hit | {ex_s, ex_i};
            check(hit, f[0] ? 16'h2 : 16'h1);
        end
        $display("test strobe done");
        close_out();
    end
endmodule // tb
